// file: include/adc_cfg_defs.svh
// Constants of the serial configuration register bank: offsets, fields,
// reset values and framing counts. Assumes inclusion by bare name.
//
// Operation
// - Port setup bits mirrored across nibbles, reset 0x18
// - Unmapped addresses and bits have no function
// - Divider field bits 2:0, ratio field plus one
// - Divider codes up to 101; higher undefined
// - Channel bits route writes; both read channel A
// - Shadowed registers apply together on transfer command
// - Global registers ignore the channel select
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH

`define CFG_ADDR_PORT   13'h0000
`define CFG_ADDR_ID     13'h0001
`define CFG_ADDR_GRADE  13'h0002
`define CFG_ADDR_CHAN   13'h0005
`define CFG_ADDR_MODES  13'h0008
`define CFG_ADDR_CLOCK  13'h0009
`define CFG_ADDR_DIV    13'h000b
`define CFG_ADDR_XFER   13'h00ff
`define CFG_ADDR_UNUSED 13'h0003

`define CFG_RST_PORT    8'h18
`define CFG_RST_CHAN    2'h3
`define CFG_RST_MODES   8'h80
`define CFG_RST_CLOCK   1'h0
`define CFG_RST_DIV     3'h0
`define CFG_RST_XFER    1'h0

`define CFG_PORT_LSB_HI 6
`define CFG_PORT_LSB_LO 1
`define CFG_PORT_SR_HI  5
`define CFG_PORT_SR_LO  2
`define CFG_MODES_MASK  8'he3
`define CFG_DIV_MAX     3'h5
`define CFG_XFER_BIT    0
`define CFG_DCS_BIT     0

`define CFG_INSTR_LAST  4'hf
`define CFG_INSTR_RW    15
`define CFG_BYTE_LAST   3'h7

`endif

// file: include/adc_cfg_pkg.sv
// Types shared by the serial configuration bank.
// Assumes nothing of its surroundings.
package adc_cfg_pkg;
  typedef logic [12:0] cfg_addr_t;
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_INSTR = 2'b01,
    PH_DATA  = 2'b11
  } spi_phase_t;
endpackage

// file: core/spi_serial_shifter.sv
// Serial framing of the three-wire port: pin synchronisers, instruction
// and data byte assembly, readback shifting. Assumes SCLK high and low
// phases each last at least four core_clk periods.
`include "adc_cfg_defs.svh"

module spi_serial_shifter
  import adc_cfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        sclk,
  input  wire logic        csbN,
  input  wire logic        sdioIn,
  input  wire logic        lsbFirst,
  input  wire logic [7:0]  txByte,
  output logic             instrStb,
  output logic [15:0]      instrWord,
  output logic             byteStb,
  output logic [7:0]       rxByte,
  output logic             sdioOut,
  output logic             sdioOe
);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pinMeta_reg;
  logic [2:0] pinSync_reg;
  logic       sclkLast_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_reg  <= 3'h2;
      pinSync_reg  <= 3'h2;
      sclkLast_reg <= 1'b0;
    end else begin
      pinMeta_reg  <= {sdioIn, csbN, sclk};
      pinSync_reg  <= pinMeta_reg;
      sclkLast_reg <= pinSync_reg[0];
    end
  end

  logic sclkRise;
  logic sclkFall;
  assign sclkRise = pinSync_reg[0] & ~sclkLast_reg;
  assign sclkFall = ~pinSync_reg[0] & sclkLast_reg;

  // ****************************************
  // Framing
  // ****************************************
  spi_phase_t  phase_reg, phase_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [15:0] shift_reg, shift_next;
  logic [7:0]  tx_reg, tx_next;
  logic        read_reg, read_next;
  logic        out_reg, out_next;
  logic        oe_reg, oe_next;
  logic        iStb_reg, iStb_next;
  logic [15:0] iWord_reg, iWord_next;
  logic        bStb_reg, bStb_next;
  logic [7:0]  rx_reg, rx_next;

  always_comb begin
    logic [7:0] loaded;
    loaded     = 8'h00;
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    tx_next    = tx_reg;
    read_next  = read_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    iStb_next  = 1'b0;
    iWord_next = iWord_reg;
    bStb_next  = 1'b0;
    rx_next    = rx_reg;
    if (pinSync_reg[1]) begin
      // Chip select high ends any frame, even one cut short
      phase_next = PH_IDLE;
      cnt_next   = 4'h0;
      read_next  = 1'b0;
      oe_next    = 1'b0;
    end else begin
      if (phase_reg == PH_IDLE) begin
        phase_next = PH_INSTR;
      end
      if (sclkRise) begin
        shift_next = {shift_reg[14:0], pinSync_reg[2]};
        cnt_next   = 4'(cnt_reg + 4'h1);
        if (phase_reg != PH_DATA) begin
          if (cnt_reg == `CFG_INSTR_LAST) begin
            phase_next = PH_DATA;
            cnt_next   = 4'h0;
            iStb_next  = 1'b1;
            iWord_next = lsbFirst ? {rev8(shift_next[7:0]), rev8(shift_next[15:8])} : shift_next;
            read_next  = iWord_next[`CFG_INSTR_RW];
          end
        end else if (cnt_reg[2:0] == `CFG_BYTE_LAST) begin
          cnt_next  = 4'h0;
          bStb_next = 1'b1;
          rx_next   = lsbFirst ? rev8(shift_next[7:0]) : shift_next[7:0];
        end
      end
      if (sclkFall && phase_reg == PH_DATA && read_reg) begin
        oe_next = 1'b1;
        if (cnt_reg[2:0] == 3'h0) begin
          loaded   = lsbFirst ? rev8(txByte) : txByte;
          out_next = loaded[7];
          tx_next  = {loaded[6:0], 1'b0};
        end else begin
          out_next = tx_reg[7];
          tx_next  = {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 16'h0000;
      tx_reg    <= 8'h00;
      read_reg  <= 1'b0;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      iStb_reg  <= 1'b0;
      iWord_reg <= 16'h0000;
      bStb_reg  <= 1'b0;
      rx_reg    <= 8'h00;
    end else begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      tx_reg    <= tx_next;
      read_reg  <= read_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      iStb_reg  <= iStb_next;
      iWord_reg <= iWord_next;
      bStb_reg  <= bStb_next;
      rx_reg    <= rx_next;
    end
  end

  assign instrStb  = iStb_reg;
  assign instrWord = iWord_reg;
  assign byteStb   = bStb_reg;
  assign rxByte    = rx_reg;
  assign sdioOut   = out_reg;
  assign sdioOe    = oe_reg;

endmodule // spi_serial_shifter

// file: core/adc_cfg_regs.sv
// Configuration register bank of the dual-channel converter, reached over
// the three-wire serial port. Assumes the pad ring resolves SDIO from
// sdioOut and sdioOe, and that SCLK is slow against core_clk.
`include "adc_cfg_defs.svh"

module adc_cfg_regs
  import adc_cfg_pkg::*;
#(
  // Arbitrary identity value
  parameter logic [7:0] PART_IDENTIFIER     = 8'h5a,
  parameter logic [2:0] SPEED_GRADE = 3'h0
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        sclk,
  input  wire logic        csbN,
  input  wire logic        sdioIn,
  output logic             sdioOut,
  output logic             sdioOe,
  output logic [7:0]       modeChA,
  output logic [7:0]       modeChB,
  output logic             dcsEnable,
  output logic [2:0]       clkDivCode,
  output logic [3:0]       clkDivideBy
);

  // ****************************************
  // Serial framing
  // ****************************************
  logic        instrStb;
  logic [15:0] instrWord;
  logic        byteStb;
  logic [7:0]  rxByte;
  logic [7:0]  txByte;
  logic        lsbFirst_reg, lsbFirst_next;

  spi_serial_shifter u_shifter (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .sclk      (sclk),
    .csbN      (csbN),
    .sdioIn    (sdioIn),
    .lsbFirst  (lsbFirst_reg),
    .txByte    (txByte),
    .instrStb  (instrStb),
    .instrWord (instrWord),
    .byteStb   (byteStb),
    .rxByte    (rxByte),
    .sdioOut   (sdioOut),
    .sdioOe    (sdioOe)
  );

  // ****************************************
  // Register state
  // ****************************************
  cfg_addr_t   addr_reg, addr_next;
  logic        isRead_reg, isRead_next;
  logic        softRst_reg, softRst_next;
  logic [1:0]  chanSel_reg, chanSel_next;
  logic [7:0]  modeMA_reg, modeMA_next;
  logic [7:0]  modeMB_reg, modeMB_next;
  logic        dcsM_reg, dcsM_next;
  logic [2:0]  divM_reg, divM_next;
  logic        xfer_reg, xfer_next;
  logic [7:0]  modeA_reg, modeA_next;
  logic [7:0]  modeB_reg, modeB_next;
  logic        dcs_reg, dcs_next;
  logic [2:0]  div_reg, div_next;
  logic [3:0]  divBy_reg, divBy_next;
  logic        wrEn;

  assign wrEn = byteStb & ~isRead_reg;

  // Readback of the master side; unmapped locations read zero
  function automatic logic [7:0] regRead(input cfg_addr_t a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      `CFG_ADDR_PORT:  d = {1'b0, lsbFirst_reg, softRst_reg, 2'b11, softRst_reg, lsbFirst_reg, 1'b0};
      `CFG_ADDR_ID:    d = PART_IDENTIFIER;
      `CFG_ADDR_GRADE: d = {1'b0, SPEED_GRADE, 4'h0};
      `CFG_ADDR_CHAN:  d = {6'h00, chanSel_reg};
      `CFG_ADDR_MODES: d = (chanSel_reg == 2'b10) ? modeMB_reg : modeMA_reg;
      `CFG_ADDR_CLOCK: d = {7'h00, dcsM_reg};
      `CFG_ADDR_DIV:   d = {5'h00, divM_reg};
      `CFG_ADDR_XFER:  d = {7'h00, xfer_reg};
      default:         d = 8'h00;
    endcase
    return d;
  endfunction

  // A process, not an assign: the function reads registers beyond its argument
  always_comb begin
    txByte = regRead(addr_reg);
  end

  always_comb begin
    addr_next     = addr_reg;
    isRead_next   = isRead_reg;
    lsbFirst_next = lsbFirst_reg;
    softRst_next  = softRst_reg;
    chanSel_next  = chanSel_reg;
    modeMA_next   = modeMA_reg;
    modeMB_next   = modeMB_reg;
    dcsM_next     = dcsM_reg;
    divM_next     = divM_reg;
    xfer_next     = xfer_reg;
    modeA_next    = modeA_reg;
    modeB_next    = modeB_reg;
    dcs_next      = dcs_reg;
    div_next      = div_reg;
    divBy_next    = divBy_reg;
    if (instrStb) begin
      addr_next   = instrWord[12:0];
      isRead_next = instrWord[`CFG_INSTR_RW];
    end else if (byteStb) begin
      // Streaming walks down in MSB-first order, up in LSB-first order
      addr_next = lsbFirst_reg ? cfg_addr_t'(addr_reg + 13'h1) : cfg_addr_t'(addr_reg - 13'h1);
    end
    if (softRst_reg) begin
      lsbFirst_next = 1'b0;
      softRst_next  = 1'b0;
      chanSel_next  = `CFG_RST_CHAN;
      modeMA_next   = `CFG_RST_MODES;
      modeMB_next   = `CFG_RST_MODES;
      dcsM_next     = `CFG_RST_CLOCK;
      divM_next     = `CFG_RST_DIV;
      xfer_next     = `CFG_RST_XFER;
      modeA_next    = `CFG_RST_MODES;
      modeB_next    = `CFG_RST_MODES;
      dcs_next      = `CFG_RST_CLOCK;
      div_next      = `CFG_RST_DIV;
      divBy_next    = 4'h1;
    end else if (xfer_reg) begin
      modeA_next = modeMA_reg;
      modeB_next = modeMB_reg;
      dcs_next   = dcsM_reg;
      div_next   = divM_reg;
      divBy_next = 4'({1'b0, divM_reg} + 4'h1);
      xfer_next  = 1'b0;
    end
    // Writes come last so a set in the clearing cycle is kept
    if (wrEn) begin
      unique case (addr_reg)
        `CFG_ADDR_PORT: begin
          lsbFirst_next = rxByte[`CFG_PORT_LSB_HI] | rxByte[`CFG_PORT_LSB_LO];
          softRst_next  = rxByte[`CFG_PORT_SR_HI] | rxByte[`CFG_PORT_SR_LO];
        end
        `CFG_ADDR_CHAN: chanSel_next = rxByte[1:0];
        `CFG_ADDR_MODES: begin
          if (chanSel_reg[0]) begin
            modeMA_next = rxByte & `CFG_MODES_MASK;
          end
          if (chanSel_reg[1]) begin
            modeMB_next = rxByte & `CFG_MODES_MASK;
          end
        end
        `CFG_ADDR_CLOCK: dcsM_next = rxByte[`CFG_DCS_BIT];
        // codes above the top one are stored unchecked
        `CFG_ADDR_DIV:  divM_next = rxByte[2:0];
        `CFG_ADDR_XFER: xfer_next = rxByte[`CFG_XFER_BIT];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg     <= 13'h0000;
      isRead_reg   <= 1'b0;
      lsbFirst_reg <= 1'b0;
      softRst_reg  <= 1'b0;
      chanSel_reg  <= `CFG_RST_CHAN;
      modeMA_reg   <= `CFG_RST_MODES;
      modeMB_reg   <= `CFG_RST_MODES;
      dcsM_reg     <= `CFG_RST_CLOCK;
      divM_reg     <= `CFG_RST_DIV;
      xfer_reg     <= `CFG_RST_XFER;
      modeA_reg    <= `CFG_RST_MODES;
      modeB_reg    <= `CFG_RST_MODES;
      dcs_reg      <= `CFG_RST_CLOCK;
      div_reg      <= `CFG_RST_DIV;
      divBy_reg    <= 4'h1;
    end else begin
      addr_reg     <= addr_next;
      isRead_reg   <= isRead_next;
      lsbFirst_reg <= lsbFirst_next;
      softRst_reg  <= softRst_next;
      chanSel_reg  <= chanSel_next;
      modeMA_reg   <= modeMA_next;
      modeMB_reg   <= modeMB_next;
      dcsM_reg     <= dcsM_next;
      divM_reg     <= divM_next;
      xfer_reg     <= xfer_next;
      modeA_reg    <= modeA_next;
      modeB_reg    <= modeB_next;
      dcs_reg      <= dcs_next;
      div_reg      <= div_next;
      divBy_reg    <= divBy_next;
    end
  end

  assign modeChA     = modeA_reg;
  assign modeChB     = modeB_reg;
  assign dcsEnable   = dcs_reg;
  assign clkDivCode  = div_reg;
  assign clkDivideBy = divBy_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_xferCmd;
    xfer_reg && !softRst_reg;
  endsequence

  sequence s_applied;
    modeChA == $past(modeMA_reg) && dcsEnable == $past(dcsM_reg) && clkDivCode == $past(divM_reg);
  endsequence

  logic [7:0] portView;

  always_comb begin
    portView = regRead(`CFG_ADDR_PORT);
  end

  a_port_mirror: assert property (
    wrEn && addr_reg == `CFG_ADDR_PORT
      |=> lsbFirst_reg == ($past(rxByte[`CFG_PORT_LSB_HI]) | $past(rxByte[`CFG_PORT_LSB_LO]))
          && portView[6] == portView[1] && portView[5] == portView[2] && portView[4:3] == 2'b11)
    else $error("port setup nibbles not mirrored");

  a_unmapped_zero: assert property (
    wrEn && addr_reg == `CFG_ADDR_UNUSED && !softRst_reg
      |=> regRead(`CFG_ADDR_UNUSED) == 8'h00 && $stable(lsbFirst_reg) && $stable(chanSel_reg)
          && $stable(modeMA_reg) && $stable(modeMB_reg) && $stable(dcsM_reg) && $stable(divM_reg))
    else $error("unmapped address access had an effect");

  a_div_ratio: assert property (
    $rose(xfer_reg) ##1 !softRst_reg |=> clkDivideBy == 4'({1'b0, clkDivCode} + 4'h1))
    else $error("divide ratio is not code plus one");

  a_div_range: assert property (
    clkDivCode <= `CFG_DIV_MAX |-> clkDivideBy <= 4'h6)
    else $error("legal divider code gives ratio above six");

  a_read_chan_a: assert property (
    chanSel_reg == 2'b11 |-> regRead(`CFG_ADDR_MODES) == modeMA_reg)
    else $error("both channels selected did not read channel A");

  a_shadow_hold: assert property (
    !xfer_reg && !softRst_reg |=> $stable(modeChA) && $stable(modeChB) && $stable(dcsEnable) && $stable(clkDivCode))
    else $error("shadowed output changed without transfer");

  a_shadow_apply: assert property (
    s_xferCmd |=> s_applied)
    else $error("transfer did not apply shadow values");

  a_global_div: assert property (
    wrEn && addr_reg == `CFG_ADDR_DIV && chanSel_reg == 2'b00 |=> divM_reg == $past(rxByte[2:0]))
    else $error("global register honoured channel select");

  a_soft_reset: assert property (
    softRst_reg && !wrEn |=> !softRst_reg && chanSel_reg == `CFG_RST_CHAN && regRead(`CFG_ADDR_PORT) == `CFG_RST_PORT)
    else $error("soft reset did not restore defaults");

endmodule // adc_cfg_regs

// file: sim/spi_host_model.sv
// Host model of the three-wire configuration port: one-byte frames.
// Assumes core_clk runs free and that SDIO is resolved here.
module spi_host_model (
  input  wire logic core_clk,
  output logic      sclk,
  output logic      csbN,
  output logic      sdioIn,
  input  wire logic sdioOut,
  input  wire logic sdioOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Pin resolution
  // ****************
  // SCLK half period of 6 clocks keeps above the 4-clock minimum
  localparam int HALF = 6;
  logic hostOe;
  logic hostBit;
  // Released line shows the inverse of the last bit, never a stale copy
  assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : ~hostBit);
  initial begin
    sclk = 1'b0;
    csbN = 1'b1;
    hostOe = 1'b0;
    hostBit = 1'b0;
  end
  // ****************
  // Frame task
  // ****************
  task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
                       input logic lsb, output logic [7:0] rdata);
    logic [15:0] instr;
    instr = {rd, 2'b00, addr};
    rdata = 8'h00;
    @(posedge core_clk);
    csbN <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      sclk <= 1'b0;
      hostOe <= !(rd && i >= 16);
      hostBit <= (i < 16) ? instr[lsb ? i : 15 - i] : wdata[lsb ? i - 16 : 23 - i];
      repeat (HALF) @(posedge core_clk);
      sclk <= 1'b1;
      if (i >= 16) begin
        rdata[lsb ? i - 16 : 23 - i] = sdioIn;
      end
      repeat (HALF - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    sclk <= 1'b0;
    hostOe <= 1'b0;
    repeat (HALF) @(posedge core_clk);
    csbN <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask
endmodule // spi_host_model

// file: sim/adc_serial_config_registers_test.sv
// Self-checking bench of the configuration register bank.
// Assumes the host model drives the port and resolves SDIO.
`include "adc_cfg_defs.svh"

module adc_serial_config_registers_test
  import adc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity value
  localparam logic [7:0] ID_VAL = 8'ha6;
  localparam logic [2:0] GRADE  = 3'h5;
  logic        coreClk = 1'b0;
  logic        arstN;
  logic        sclk;
  logic        csbN;
  logic        sdioIn;
  logic        sdioOut;
  logic        sdioOe;
  logic [7:0]  modeChA;
  logic [7:0]  modeChB;
  logic        dcsEnable;
  logic [2:0]  clkDivCode;
  logic [3:0]  clkDivideBy;
  int          nFail = 0;
  int          checkCount = 0;
  logic [31:0] lfsrState = 32'hafa2;

  always #20 coreClk = ~coreClk;

  adc_cfg_regs #(.PART_IDENTIFIER(ID_VAL), .SPEED_GRADE(GRADE)) u_adc_cfg_regs (
    .core_clk(coreClk), .arst_n(arstN), .sclk(sclk), .csbN(csbN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe), .modeChA(modeChA), .modeChB(modeChB),
    .dcsEnable(dcsEnable), .clkDivCode(clkDivCode), .clkDivideBy(clkDivideBy));

  spi_host_model u_spi_host_model (
    .core_clk(coreClk), .sclk(sclk), .csbN(csbN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe));

  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] rnd();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState[7:0];
  endfunction
  function automatic logic [7:0] masked(input logic [7:0] v);
    return v & 8'he3;
  endfunction
  function automatic logic [7:0] ratio(input logic [2:0] c);
    return {4'h0, 1'b0, c} + 8'h01;
  endfunction
  task automatic chk(input string what, input logic [7:0] expv, input logic [7:0] seen);
    checkCount++;
    if (seen !== expv) begin
      nFail++;
      $display("unexpected %s: expected %h, seen %h", what, expv, seen);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb = 1'b0);
    logic [7:0] junk;
    u_spi_host_model.frame(1'b0, a, d, lsb, junk);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] expv, input logic lsb = 1'b0);
    logic [7:0] got;
    u_spi_host_model.frame(1'b1, a, 8'h00, lsb, got);
    chk($sformatf("reg %h", a), expv, got);
    // Device must have let go of SDIO once chip select is high
    chk("sdioOe", 8'h00, {7'h00, sdioOe});
  endtask
  task automatic outs(input logic [7:0] a, input logic [7:0] b, input logic d, input logic [2:0] c);
    chk("modeChA", a, modeChA);
    chk("modeChB", b, modeChB);
    chk("dcsEnable", {7'h00, d}, {7'h00, dcsEnable});
    chk("clkDivCode", {5'h00, c}, {5'h00, clkDivCode});
    chk("clkDivideBy", ratio(c), {4'h0, clkDivideBy});
  endtask
  task automatic closeOut();
    $display("comparisons %0d, mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************
  // Watchdog
  // ****************
  initial begin
    repeat (60000) @(posedge coreClk);
    nFail++;
    closeOut();
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    logic [7:0] ma;
    logic [7:0] mb;
    logic [2:0] dv;
    arstN = 1'b0;
    repeat (2) @(posedge coreClk);
    arstN <= 1'b1;
    repeat (3) @(posedge coreClk);
    outs(8'h80, 8'h80, 1'b0, 3'h0);
    rdc(`CFG_ADDR_PORT, 8'h18);
    rdc(`CFG_ADDR_ID, ID_VAL);
    rdc(`CFG_ADDR_GRADE, {1'b0, GRADE, 4'h0});
    rdc(`CFG_ADDR_CHAN, 8'h03);
    rdc(`CFG_ADDR_MODES, 8'h80);
    rdc(`CFG_ADDR_DIV, 8'h00);
    rdc(`CFG_ADDR_XFER, 8'h00);
    // Read-only and unmapped places ignore writes
    wr(`CFG_ADDR_ID, ~ID_VAL);
    rdc(`CFG_ADDR_ID, ID_VAL);
    wr(`CFG_ADDR_UNUSED, 8'h55);
    rdc(`CFG_ADDR_UNUSED, 8'h00);
    // Local modes per channel, globals under a single-channel select
    ma = rnd();
    mb = rnd();
    dv = 3'(rnd() % 8'h06);
    wr(`CFG_ADDR_CHAN, 8'h01);
    wr(`CFG_ADDR_MODES, ma);
    wr(`CFG_ADDR_CHAN, 8'h02);
    wr(`CFG_ADDR_MODES, mb);
    wr(`CFG_ADDR_CLOCK, 8'h01);
    wr(`CFG_ADDR_DIV, {5'h00, dv});
    outs(8'h80, 8'h80, 1'b0, 3'h0);
    rdc(`CFG_ADDR_MODES, masked(mb));
    rdc(`CFG_ADDR_CLOCK, 8'h01);
    wr(`CFG_ADDR_CHAN, 8'h03);
    rdc(`CFG_ADDR_MODES, masked(ma));
    wr(`CFG_ADDR_XFER, 8'h01);
    outs(masked(ma), masked(mb), 1'b1, dv);
    rdc(`CFG_ADDR_XFER, 8'h00);
    // codes kept at or below 5
    wr(`CFG_ADDR_CHAN, 8'h00);
    for (int k = 5; k >= 0; k--) begin
      dv = 3'(k);
      wr(`CFG_ADDR_DIV, {5'h00, dv});
      wr(`CFG_ADDR_XFER, 8'h01);
      outs(masked(ma), masked(mb), 1'b1, dv);
      rdc(`CFG_ADDR_DIV, {5'h00, dv});
    end
    // Soft reset through both mirrored bits
    wr(`CFG_ADDR_PORT, 8'h3c);
    rdc(`CFG_ADDR_PORT, 8'h18);
    rdc(`CFG_ADDR_CHAN, 8'h03);
    rdc(`CFG_ADDR_CLOCK, 8'h00);
    outs(8'h80, 8'h80, 1'b0, 3'h0);
    // Shift-order switch, then soft reset sent LSB first
    wr(`CFG_ADDR_PORT, 8'h5a);
    rdc(`CFG_ADDR_PORT, 8'h5a, 1'b1);
    wr(`CFG_ADDR_CHAN, 8'h02, 1'b1);
    rdc(`CFG_ADDR_CHAN, 8'h02, 1'b1);
    wr(`CFG_ADDR_PORT, 8'h7e, 1'b1);
    rdc(`CFG_ADDR_PORT, 8'h18);
    // Mid-run reset over a non-default active state
    wr(`CFG_ADDR_CLOCK, 8'h01);
    wr(`CFG_ADDR_XFER, 8'h01);
    chk("dcsEnable", 8'h01, {7'h00, dcsEnable});
    arstN <= 1'b0;
    repeat (2) @(posedge coreClk);
    arstN <= 1'b1;
    repeat (3) @(posedge coreClk);
    outs(8'h80, 8'h80, 1'b0, 3'h0);
    rdc(`CFG_ADDR_CLOCK, 8'h00);
    closeOut();
  end
endmodule // adc_serial_config_registers_test
